// [design/pmt_pkg.sv]
package pmt_pkg;
  // Register byte addresses on the APB bus
  localparam logic [11:0] PMT_OFF_CONTROL = 12'h000;
  localparam logic [11:0] PMT_OFF_COUNT   = 12'h004;
  localparam logic [11:0] PMT_OFF_LIMIT   = 12'h008;
  localparam logic [11:0] PMT_OFF_STATUS  = 12'h00C;
  localparam logic [11:0] PMT_OFF_MASK    = 12'h010;

  // Control field positions
  localparam int PMT_CTL_PRE_LSB  = 0;
  localparam int PMT_CTL_RUN_BIT  = 2;
  localparam int PMT_CTL_POST_LSB = 3;
  localparam logic [7:0] PMT_CTL_WMASK = 8'h7F;

  // Reset values
  localparam logic [7:0] PMT_RST_CONTROL = 8'h00;
  localparam logic [7:0] PMT_RST_COUNT   = 8'h00;
  localparam logic [7:0] PMT_RST_LIMIT   = 8'hFF;

  // Instruction clock is the bus clock divided by four
  localparam logic [1:0] PMT_INSTR_DIV_LAST = 2'h3;

  // Pre-divider terminal counts
  localparam logic [3:0] PMT_PRE_LAST_1  = 4'h0;
  localparam logic [3:0] PMT_PRE_LAST_4  = 4'h3;
  localparam logic [3:0] PMT_PRE_LAST_16 = 4'hF;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] count;
    logic [7:0] limit;
    logic       status;
    logic       mask;
    logic [1:0] phase;
    logic [3:0] pre;
    logic [3:0] post;
    logic       match;
    logic       acc;
    logic [31:0] rdata;
  } pmt_state_t;
endpackage : pmt_pkg

// [design/pmt_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module pmt_timer
  import pmt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             serial_shift_tick,
  output logic             pwm_period_match,
  output logic [7:0]       pwm_time_base
);
  pmt_state_t st_reg;
  pmt_state_t st_next;

  logic       wr_en;
  logic       rd_en;
  logic       hit;
  logic       instr_tick;
  logic       pre_done;
  logic       run;
  logic [3:0] pre_last;
  logic [3:0] post_last;
  logic       flag_set;
  logic       acc_first;
  logic       acc_last;
  logic       rd_clr;

  // Read data is registered at the first access edge; writes and the read clear
  // wait for the edge where pready is seen, so no access takes effect twice
  assign acc_first = psel & penable & ~st_reg.acc & clk_en;
  assign acc_last  = psel & penable & st_reg.acc & clk_en;
  assign wr_en     = acc_last & pwrite;
  assign rd_en     = acc_first & ~pwrite;
  assign rd_clr    = acc_last & ~pwrite & (paddr == PMT_OFF_STATUS);
  assign hit   = (paddr == PMT_OFF_CONTROL) | (paddr == PMT_OFF_COUNT) |
                 (paddr == PMT_OFF_LIMIT) | (paddr == PMT_OFF_STATUS) |
                 (paddr == PMT_OFF_MASK);
  assign run        = st_reg.control[PMT_CTL_RUN_BIT];
  assign post_last  = st_reg.control[PMT_CTL_POST_LSB +: 4];
  assign instr_tick = run & (st_reg.phase == PMT_INSTR_DIV_LAST);

  always_comb begin
    unique case (st_reg.control[PMT_CTL_PRE_LSB +: 2])
      2'h0:    pre_last = PMT_PRE_LAST_1;
      2'h1:    pre_last = PMT_PRE_LAST_4;
      default: pre_last = PMT_PRE_LAST_16;
    endcase
  end

  assign pre_done = instr_tick & (st_reg.pre == pre_last);
  assign flag_set = pre_done & (st_reg.count == st_reg.limit) &
                    (st_reg.post == post_last);

  always_comb begin
    st_next = st_reg;
    st_next.match = 1'b0;
    st_next.acc   = psel & penable & ~st_reg.acc;
    if (run) begin
      st_next.phase = st_reg.phase + 2'h1;
    end
    if (instr_tick) begin
      st_next.pre = pre_done ? 4'h0 : st_reg.pre + 4'h1;
    end
    if (pre_done) begin
      if (st_reg.count == st_reg.limit) begin
        st_next.count = 8'h00;
        st_next.match = 1'b1;
        st_next.post  = (st_reg.post == post_last) ? 4'h0 : st_reg.post + 4'h1;
      end else begin
        st_next.count = st_reg.count + 8'h01;
      end
    end
    if (wr_en) begin
      unique case (paddr)
        PMT_OFF_CONTROL: begin
          st_next.control = pwdata[7:0] & PMT_CTL_WMASK;
          st_next.pre  = 4'h0;
          st_next.post = 4'h0;
          st_next.phase = 2'h0;
        end
        PMT_OFF_COUNT: begin
          st_next.count = pwdata[7:0];
          st_next.pre  = 4'h0;
          st_next.post = 4'h0;
          st_next.phase = 2'h0;
        end
        PMT_OFF_LIMIT: st_next.limit = pwdata[7:0];
        PMT_OFF_MASK:  st_next.mask  = pwdata[0];
        default: ;
      endcase
    end
    st_next.rdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        PMT_OFF_CONTROL: st_next.rdata = {24'h000000, st_reg.control};
        PMT_OFF_COUNT:   st_next.rdata = {24'h000000, st_reg.count};
        PMT_OFF_LIMIT:   st_next.rdata = {24'h000000, st_reg.limit};
        PMT_OFF_STATUS:  st_next.rdata = {31'h0, st_reg.status};
        PMT_OFF_MASK:    st_next.rdata = {31'h0, st_reg.mask};
        default:         st_next.rdata = 32'h0000_0000;
      endcase
    end
    // Only a flag that the read reported is cleared, so a later event is kept
    if (rd_clr) begin
      st_next.status = st_reg.status & ~st_reg.rdata[0];
    end
    // Set wins over the read clear
    if (flag_set) begin
      st_next.status = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.control <= PMT_RST_CONTROL;
      st_reg.count   <= PMT_RST_COUNT;
      st_reg.limit   <= PMT_RST_LIMIT;
      st_reg.status  <= 1'b0;
      st_reg.mask    <= 1'b0;
      st_reg.phase   <= 2'h0;
      st_reg.pre     <= 4'h0;
      st_reg.post    <= 4'h0;
      st_reg.match   <= 1'b0;
      st_reg.acc     <= 1'b0;
      st_reg.rdata   <= 32'h0000_0000;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Read data is registered, so every access takes one wait state
  assign pready            = st_reg.acc;
  assign pslverr           = st_reg.acc & ~hit;
  assign prdata            = st_reg.rdata;
  assign irq               = st_reg.status & st_reg.mask;
  assign serial_shift_tick = st_reg.match;
  assign pwm_period_match  = st_reg.match;
  assign pwm_time_base     = st_reg.count;

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & pre_done & (st_reg.count == st_reg.limit) & ~wr_en) |=>
        (st_reg.count == 8'h00) & st_reg.match;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap at limit");

  property p_stop_hold;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & ~run & ~wr_en) |=> $stable(st_reg.count) & ~st_reg.match;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped timer moved");

  property p_ctl_keeps_count;
    @(posedge pclk) disable iff (!presetn)
      (wr_en & (paddr == PMT_OFF_CONTROL) & ~pre_done) |=>
        (st_reg.count == $past(st_reg.count)) & (st_reg.pre == 4'h0) & (st_reg.post == 4'h0);
  endproperty
  a_ctl_keeps_count: assert property (p_ctl_keeps_count) else $error("control write bad");

  property p_cnt_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en & (paddr == PMT_OFF_COUNT)) |=>
        (st_reg.count == $past(pwdata[7:0])) & (st_reg.pre == 4'h0);
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("count write bad");

  property p_bit7;
    @(posedge pclk) disable iff (!presetn) st_reg.control[7] == 1'b0;
  endproperty
  a_bit7: assert property (p_bit7) else $error("control bit 7 set");

  property p_tick_rate;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & instr_tick) |=> ~instr_tick;
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("instruction tick too fast");

  property p_flag;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & flag_set) |=> st_reg.status;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");

  property p_post_bound;
    @(posedge pclk) disable iff (!presetn) st_reg.post <= post_last | $past(wr_en);
  endproperty
  a_post_bound: assert property (p_post_bound) else $error("post-divider overran");

  property p_limit_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en & (paddr == PMT_OFF_LIMIT)) |=> st_reg.limit == $past(pwdata[7:0]);
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit write lost");

  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & pre_done & (st_reg.count != st_reg.limit) & ~wr_en) |=>
        (st_reg.count == 8'($past(st_reg.count) + 8'h01));
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_no_step;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & ~pre_done & ~wr_en) |=> $stable(st_reg.count);
  endproperty
  a_no_step: assert property (p_no_step) else $error("counter stepped early");

  property p_pre_bound;
    @(posedge pclk) disable iff (!presetn) st_reg.pre <= pre_last | $past(wr_en);
  endproperty
  a_pre_bound: assert property (p_pre_bound) else $error("pre-divider overran");

  property p_cnt_clr_post;
    @(posedge pclk) disable iff (!presetn)
      (wr_en & (paddr == PMT_OFF_COUNT)) |=> (st_reg.post == 4'h0) & (st_reg.phase == 2'h0);
  endproperty
  a_cnt_clr_post: assert property (p_cnt_clr_post) else $error("post not cleared");

  property p_stopped_no_flag;
    @(posedge pclk) disable iff (!presetn) (clk_en & ~run) |-> ~flag_set & ~pre_done;
  endproperty
  a_stopped_no_flag: assert property (p_stopped_no_flag) else $error("flag while stopped");

  property p_match_pulse;
    @(posedge pclk) disable iff (!presetn) (clk_en & st_reg.match) |=> ~st_reg.match;
  endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("match pulse too long");

  property p_status_clear;
    @(posedge pclk) disable iff (!presetn)
      (rd_clr & ~flag_set & st_reg.rdata[0]) |=> ~st_reg.status;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("flag not cleared");

  property p_ctl_read;
    @(posedge pclk) disable iff (!presetn)
      (rd_en & (paddr == PMT_OFF_CONTROL)) |=> (prdata[31:7] == 25'h0000000);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read bit 7");

  property p_time_base;
    @(posedge pclk) disable iff (!presetn)
      (clk_en & st_reg.match) |-> (pwm_time_base == 8'h00) & pwm_period_match;
  endproperty
  a_time_base: assert property (p_time_base) else $error("time base off at match");
endmodule : pmt_timer
`default_nettype wire

// [sim/pmt_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmt_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic        irq;
  wire logic        sst;
  wire logic        ppm;
  wire logic [7:0]  ptb;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          t;
  int          cnt;
  int          cnt2;

  always #2.5 pclk = ~pclk;

  pmt_timer dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .serial_shift_tick(sst),
    .pwm_period_match(ppm), .pwm_time_base(ptb));

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is seen at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk(32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // Cycles between two successive changes of the time base
  task automatic gap(output int g);
    logic [7:0] v;
    g = 0;
    @(negedge pclk); v = ptb;
    while (ptb === v && g < 300) begin @(negedge pclk); g++; end
    v = ptb; g = 0;
    while (ptb === v && g < 300) begin @(negedge pclk); g++; end
  endtask : gap

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(PMT_OFF_CONTROL, 32'h00);
    rdc(PMT_OFF_LIMIT, 32'hFF);
    rdc(PMT_OFF_STATUS, 32'h0);
    rdc(PMT_OFF_MASK, 32'h0);
    repeat (50) @(negedge pclk);
    rdc(PMT_OFF_COUNT, 32'h00);
    apb(1'b1, PMT_OFF_LIMIT, 32'h5A); rdc(PMT_OFF_LIMIT, 32'h5A);
    apb(1'b1, PMT_OFF_COUNT, 32'h2A); apb(1'b1, PMT_OFF_CONTROL, 32'h78);
    rdc(PMT_OFF_COUNT, 32'h2A);
    rdc(PMT_OFF_CONTROL, 32'h78);
    apb(1'b1, PMT_OFF_CONTROL, 32'h80); rdc(PMT_OFF_CONTROL, 32'h00);
    apb(1'b0, 12'h020, 32'h0); chk(rd, 32'h0); chk(er, 1'b1);
    apb(1'b1, PMT_OFF_LIMIT, 32'hFF);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, PMT_OFF_CONTROL, 32'h04 | p);
      gap(t); chk(t, (p == 0) ? 4 : (p == 1) ? 16 : 64);
    end
    apb(1'b1, PMT_OFF_COUNT, 32'h00); apb(1'b1, PMT_OFF_LIMIT, 32'h03);
    apb(1'b1, PMT_OFF_CONTROL, 32'h04);
    t = 0;
    while (ptb !== 8'h03 && t < 100) begin @(negedge pclk); t++; end
    t = 0;
    while (ptb === 8'h03 && t < 100) begin @(negedge pclk); t++; end
    chk(ptb, 8'h00);
    cnt = 0; cnt2 = 0;
    repeat (160) begin @(negedge pclk); cnt += sst; cnt2 += ppm; end
    chk(cnt, 10);
    chk(cnt2, 10);
    // Limit 1 gives a match every eight cycles, short enough for 1:16
    apb(1'b1, PMT_OFF_LIMIT, 32'h01); apb(1'b1, PMT_OFF_MASK, 32'h1);
    for (int j = 0; j < 3; j++) begin
      int n;
      n = (j == 0) ? 0 : (j == 1) ? 1 : 15;
      apb(1'b1, PMT_OFF_CONTROL, 32'h00); apb(1'b0, PMT_OFF_STATUS, 32'h0);
      apb(1'b1, PMT_OFF_COUNT, 32'h00); apb(1'b1, PMT_OFF_CONTROL, (n << 3) | 32'h04);
      cnt = 0; t = 0;
      while (t < 400) begin
        @(negedge pclk); t++;
        if (ppm === 1'b1) cnt++;
        if (irq === 1'b1) break;
      end
      chk(cnt, n + 1);
    end
    rdc(PMT_OFF_STATUS, 32'h1);
    @(negedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, PMT_OFF_CONTROL, 32'h00); apb(1'b0, PMT_OFF_COUNT, 32'h0);
    t = rd; cnt = 0;
    repeat (100) begin @(negedge pclk); cnt += ppm; end
    rdc(PMT_OFF_COUNT, t);
    chk(cnt, 0);
    test_done();
  end
endmodule : testbench
`default_nettype wire
